// file: design/rtc_unit.sv
// Operation
// (RULE1) Left rotate: shift up, carry into bit 0.
// (RULE2) Left rotate: carry takes old bit 7.
// (RULE3) Right rotate: shift down, carry into bit 7.
// (RULE4) Right rotate: carry takes old bit 0.
// (RULE5) Negative flag equals result bit 7.
// (RULE6) Zero flag set when result is zero.
// (RULE7) Overflow flag is negative XOR carry.
// (RULE8) Opcodes 75/65 rotate memory byte left.
// (RULE9) Opcodes 76/66 rotate memory byte right.
// (RULE10) Opcode 45 rotates accumulator A left.
// (RULE11) Opcode 55 rotates accumulator B left.
// (RULE12) Opcode 46 rotates accumulator A right.
// (RULE13) Opcode 56 rotates accumulator B right.
// (RULE14) Carry persists between consecutive rotates.
// (RULE15) Other flag register bits stay unchanged.
// (RULE16) Memory operand: read, rotate, write back.
`timescale 1ns/100ps
`default_nettype none
module rtc_unit
  import rtc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic op_valid,
  input wire logic [7:0] op_code,
  input wire logic [15:0] op_addr,
  output logic op_ready,
  output logic op_done,
  input wire logic flag_load,
  input wire logic [7:0] flag_load_value,
  input wire logic acc_a_load,
  input wire logic acc_b_load,
  input wire logic [7:0] acc_load_value,
  output logic [7:0] acc_a,
  output logic [7:0] acc_b,
  output logic [7:0] flag_register,
  output logic illegal_op,
  output logic mem_rd,
  output logic mem_wr,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_ack
);
  typedef enum logic [1:0] {RTC_IDLE, RTC_READ, RTC_WRITE} rtc_state_e;
  typedef struct packed {
    rtc_state_e state;
    logic dir_right;
    logic done;
    logic illegal;
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic [7:0] acc_a;
    logic [7:0] acc_b;
    logic [7:0] flags;
  } rtc_regs_s;

  rtc_regs_s r;
  rtc_regs_s next_r;
  rtc_alu_if alu_bus ();

  rtc_rotator u_rot (
    .alu(alu_bus)
  );

  // Decodes one opcode into operand source, direction and legality.
  function automatic logic [3:0] rtc_decode(input logic [7:0] op);
    case (op)
      OP_LEFT_MEM_EXT, OP_LEFT_MEM_IDX: rtc_decode = {1'b1, 1'b0, RTC_SRC_MEM}; // RULE8
      OP_RIGHT_MEM_EXT, OP_RIGHT_MEM_IDX: rtc_decode = {1'b1, 1'b1, RTC_SRC_MEM}; // RULE9
      OP_LEFT_A: rtc_decode = {1'b1, 1'b0, RTC_SRC_A}; // RULE10
      OP_LEFT_B: rtc_decode = {1'b1, 1'b0, RTC_SRC_B}; // RULE11
      OP_RIGHT_A: rtc_decode = {1'b1, 1'b1, RTC_SRC_A}; // RULE12
      OP_RIGHT_B: rtc_decode = {1'b1, 1'b1, RTC_SRC_B}; // RULE13
      default: rtc_decode = 4'h0;
    endcase
  endfunction

  logic [3:0] dec;
  logic dec_ok;
  logic dec_right;
  rtc_src_e dec_src;
  logic take;

  assign dec = rtc_decode(op_code);
  assign dec_ok = dec[3];
  assign dec_right = dec[2];
  assign dec_src = rtc_src_e'(dec[1:0]);
  assign op_ready = (r.state == RTC_IDLE);
  assign take = clk_en && op_valid && op_ready;

  // The rotator is shared by accumulator and memory paths; only one runs per cycle.
  always_comb begin
    alu_bus.carry_in = r.flags[FLG_C]; // RULE14
    if (r.state == RTC_READ) begin
      alu_bus.operand = mem_rdata;
      alu_bus.dir_right = r.dir_right;
    end else begin
      alu_bus.operand = (dec_src == RTC_SRC_B) ? r.acc_b : r.acc_a;
      alu_bus.dir_right = dec_right;
    end
  end

  // Applies the four arithmetic flags and leaves S, X, H and I alone.
  function automatic logic [7:0] rtc_flags(input logic [7:0] f, input logic n,
      input logic z, input logic v, input logic c);
    logic [7:0] o;
    o = f; // RULE15
    o[FLG_N] = n;
    o[FLG_Z] = z;
    o[FLG_V] = v;
    o[FLG_C] = c;
    rtc_flags = o;
  endfunction

  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    if (flag_load) begin
      next_r.flags = flag_load_value;
    end
    if (acc_a_load) begin
      next_r.acc_a = acc_load_value;
    end
    if (acc_b_load) begin
      next_r.acc_b = acc_load_value;
    end
    case (r.state)
      RTC_IDLE: begin
        if (take) begin
          next_r.illegal = !dec_ok;
          if (!dec_ok) begin
            next_r.done = 1'b1;
          end else if (dec_src == RTC_SRC_MEM) begin
            next_r.state = RTC_READ; // RULE16
            next_r.dir_right = dec_right;
            next_r.addr = op_addr;
            next_r.rd = 1'b1;
          end else begin
            next_r.flags = rtc_flags(r.flags, alu_bus.neg_out, alu_bus.zero_out,
              alu_bus.ovf_out, alu_bus.carry_out);
            if (dec_src == RTC_SRC_A) begin
              next_r.acc_a = alu_bus.result; // RULE10
            end else begin
              next_r.acc_b = alu_bus.result; // RULE11
            end
            next_r.done = 1'b1;
          end
        end
      end
      RTC_READ: begin
        if (mem_ack) begin
          next_r.rd = 1'b0;
          next_r.wr = 1'b1;
          next_r.wdata = alu_bus.result; // RULE16
          next_r.flags = rtc_flags(r.flags, alu_bus.neg_out, alu_bus.zero_out,
            alu_bus.ovf_out, alu_bus.carry_out);
          next_r.state = RTC_WRITE;
        end
      end
      RTC_WRITE: begin
        if (mem_ack) begin
          next_r.wr = 1'b0;
          next_r.done = 1'b1;
          next_r.state = RTC_IDLE;
        end
      end
      default: next_r.state = RTC_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      r <= '{state: RTC_IDLE, dir_right: 1'b0, done: 1'b0, illegal: 1'b0, rd: 1'b0,
        wr: 1'b0, addr: ADDR_RST, wdata: ACC_RST, acc_a: ACC_RST, acc_b: ACC_RST,
        flags: FLAGS_RST};
    end else if (clk_en) begin
      r <= next_r;
    end
  end

  assign op_done = r.done;
  assign illegal_op = r.illegal;
  assign mem_rd = r.rd;
  assign mem_wr = r.wr;
  assign mem_addr = r.addr;
  assign mem_wdata = r.wdata;
  assign acc_a = r.acc_a;
  assign acc_b = r.acc_b;
  assign flag_register = r.flags;

  // The pre-operation values are taken with $past, so no extra state sits outside the struct.
  sequence s_left_a;
    clk_en && op_valid && op_ready && op_code == OP_LEFT_A && !acc_a_load && !flag_load;
  endsequence
  sequence s_right_a;
    clk_en && op_valid && op_ready && op_code == OP_RIGHT_A && !acc_a_load && !flag_load;
  endsequence
  sequence s_left_b;
    clk_en && op_valid && op_ready && op_code == OP_LEFT_B && !acc_b_load && !flag_load;
  endsequence
  sequence s_right_b;
    clk_en && op_valid && op_ready && op_code == OP_RIGHT_B && !acc_b_load && !flag_load;
  endsequence
  sequence s_acc_op;
    clk_en && op_valid && op_ready && !flag_load
      && (op_code == OP_LEFT_A || op_code == OP_RIGHT_A
      || op_code == OP_LEFT_B || op_code == OP_RIGHT_B);
  endsequence
  sequence s_mem_start;
    clk_en && op_valid && op_ready
      && (op_code == OP_LEFT_MEM_EXT || op_code == OP_LEFT_MEM_IDX
      || op_code == OP_RIGHT_MEM_EXT || op_code == OP_RIGHT_MEM_IDX);
  endsequence

  property p_left_a_res;
    @(posedge sys_clk) disable iff (rst)
    s_left_a |=> acc_a == {$past(acc_a[6:0]), $past(flag_register[FLG_C])}
      && flag_register[FLG_C] == $past(acc_a[7]);
  endproperty
  a_left_a_res: assert property (p_left_a_res) else $error("left rotate of A wrong"); // RULE1
  property p_left_a_c;
    @(posedge sys_clk) disable iff (rst)
    s_left_a |=> flag_register[FLG_C] == $past(acc_a[7]);
  endproperty
  a_left_a_c: assert property (p_left_a_c) else $error("left rotate carry wrong"); // RULE2
  property p_right_a_res;
    @(posedge sys_clk) disable iff (rst)
    s_right_a |=> acc_a == {$past(flag_register[FLG_C]), $past(acc_a[7:1])}
      && flag_register[FLG_C] == $past(acc_a[0]);
  endproperty
  a_right_a_res: assert property (p_right_a_res) else $error("right rotate of A wrong"); // RULE3
  property p_right_b_res;
    @(posedge sys_clk) disable iff (rst)
    s_right_b |=> acc_b == {$past(flag_register[FLG_C]), $past(acc_b[7:1])}
      && flag_register[FLG_C] == $past(acc_b[0]);
  endproperty
  a_right_b_res: assert property (p_right_b_res) else $error("right rotate of B wrong"); // RULE4
  property p_left_b_nzv;
    @(posedge sys_clk) disable iff (rst)
    s_left_b |=> acc_b == {$past(acc_b[6:0]), $past(flag_register[FLG_C])}
      && flag_register[FLG_N] == acc_b[7]
      && flag_register[FLG_Z] == (acc_b == 8'h00)
      && flag_register[FLG_V] == (flag_register[FLG_N] ^ flag_register[FLG_C]);
  endproperty
  a_left_b_nzv: assert property (p_left_b_nzv) else $error("B flags wrong"); // RULE5
  property p_keep;
    @(posedge sys_clk) disable iff (rst)
    s_acc_op |=> flag_register[7:4] == $past(flag_register[7:4]);
  endproperty
  a_keep: assert property (p_keep) else $error("upper flags changed"); // RULE15
  property p_mem;
    @(posedge sys_clk) disable iff (rst)
    s_mem_start |=> mem_rd && !mem_wr && mem_addr == $past(op_addr);
  endproperty
  a_mem: assert property (p_mem) else $error("memory read not issued"); // RULE16
  property p_wb;
    @(posedge sys_clk) disable iff (rst)
    clk_en && mem_rd && mem_ack |=> mem_wr && !mem_rd && mem_addr == $past(mem_addr)
      && flag_register[FLG_Z] == (mem_wdata == 8'h00);
  endproperty
  a_wb: assert property (p_wb) else $error("write back wrong"); // RULE6
endmodule
`default_nettype wire

// file: design/rtc_pkg.sv
package rtc_pkg;
  localparam logic [7:0] OP_LEFT_MEM_EXT = 8'h75;
  localparam logic [7:0] OP_LEFT_MEM_IDX = 8'h65;
  localparam logic [7:0] OP_RIGHT_MEM_EXT = 8'h76;
  localparam logic [7:0] OP_RIGHT_MEM_IDX = 8'h66;
  localparam logic [7:0] OP_LEFT_A = 8'h45;
  localparam logic [7:0] OP_LEFT_B = 8'h55;
  localparam logic [7:0] OP_RIGHT_A = 8'h46;
  localparam logic [7:0] OP_RIGHT_B = 8'h56;
  localparam int FLG_C = 0;
  localparam int FLG_V = 1;
  localparam int FLG_Z = 2;
  localparam int FLG_N = 3;
  localparam logic [7:0] FLAGS_RST = 8'hd0;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [15:0] ADDR_RST = 16'h0000;
  typedef enum logic [1:0] {RTC_SRC_A, RTC_SRC_B, RTC_SRC_MEM} rtc_src_e;
endpackage

// file: design/rtc_alu_if.sv
`timescale 1ns/100ps
`default_nettype none
interface rtc_alu_if;
  logic [7:0] operand;
  logic dir_right;
  logic carry_in;
  logic [7:0] result;
  logic carry_out;
  logic neg_out;
  logic zero_out;
  logic ovf_out;
  modport core (output operand, output dir_right, output carry_in,
    input result, input carry_out, input neg_out, input zero_out, input ovf_out);
  modport alu (input operand, input dir_right, input carry_in,
    output result, output carry_out, output neg_out, output zero_out, output ovf_out);
endinterface
`default_nettype wire

// file: design/rtc_rotator.sv
`timescale 1ns/100ps
`default_nettype none
module rtc_rotator
  import rtc_pkg::*;
(
  rtc_alu_if.alu alu
);
  always_comb begin
    if (alu.dir_right) begin
      alu.result = {alu.carry_in, alu.operand[7:1]}; // RULE3
      alu.carry_out = alu.operand[0]; // RULE4
    end else begin
      alu.result = {alu.operand[6:0], alu.carry_in}; // RULE1
      alu.carry_out = alu.operand[7]; // RULE2
    end
    alu.neg_out = alu.result[7]; // RULE5
    alu.zero_out = (alu.result == 8'h00); // RULE6
    alu.ovf_out = alu.neg_out ^ alu.carry_out; // RULE7
  end
endmodule
`default_nettype wire

// file: testbench/rtc_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module rtc_mem_model
  import rtc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic slow,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata,
  output logic mem_ack
);
  logic [7:0] mem [0:65535];
  logic [7:0] rd_q;
  logic [1:0] wait_cnt;
  // Outside an acknowledge the data shows the inverse of the last byte, so a late sample is caught.
  assign mem_rdata = mem_ack ? rd_q : ~rd_q;
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mem_ack <= 1'b0;
      wait_cnt <= 2'h0;
      rd_q <= 8'h00;
    end else if (mem_ack) begin
      mem_ack <= 1'b0;
    end else if (mem_rd || mem_wr) begin
      if (slow && wait_cnt != 2'h3) begin
        wait_cnt <= wait_cnt + 2'h1;
      end else begin
        wait_cnt <= 2'h0;
        mem_ack <= 1'b1;
        if (mem_rd) begin
          rd_q <= mem[mem_addr];
        end else begin
          mem[mem_addr] <= mem_wdata;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: testbench/rtc_unit_tb.sv
`timescale 1ns/100ps
`default_nettype none
module rtc_unit_tb
  import rtc_pkg::*;
();
  logic sys_clk, rst, clk_en, op_valid, flag_load, acc_a_load, acc_b_load, slow;
  logic op_ready, op_done, illegal_op, mem_rd, mem_wr, mem_ack;
  logic [7:0] op_code, flag_load_value, acc_load_value, acc_a, acc_b, flag_register;
  logic [7:0] mem_wdata, mem_rdata, ea, eb, ef, em;
  logic [15:0] op_addr, mem_addr;
  int mismatches, num_checks;
  rtc_unit i_dut(.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .op_valid(op_valid),
    .op_code(op_code), .op_addr(op_addr), .op_ready(op_ready), .op_done(op_done),
    .flag_load(flag_load), .flag_load_value(flag_load_value), .acc_a_load(acc_a_load),
    .acc_b_load(acc_b_load), .acc_load_value(acc_load_value), .acc_a(acc_a), .acc_b(acc_b),
    .flag_register(flag_register), .illegal_op(illegal_op), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
  rtc_mem_model i_mem(.sys_clk(sys_clk), .rst(rst), .slow(slow), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic ld(input int which, input logic [7:0] v);
    flag_load = (which == 0);
    acc_a_load = (which == 1);
    acc_b_load = (which == 2);
    flag_load_value = v;
    acc_load_value = v;
    @(posedge sys_clk);
    #1;
    {flag_load, acc_a_load, acc_b_load} = 3'h0;
    if (which == 0) ef = v;
    else if (which == 1) ea = v;
    else eb = v;
  endtask
  task automatic exec(input logic [7:0] code, input logic [15:0] addr);
    logic [7:0] src;
    logic [8:0] r;
    logic lgl;
    int n;
    lgl = (code[3:0] == 4'h5 || code[3:0] == 4'h6) && code[7:4] >= 4'h4 && code[7:4] <= 4'h7;
    em = i_mem.mem[addr];
    src = code[7:4] == 4'h4 ? ea : code[7:4] == 4'h5 ? eb : em;
    r = code[3:0] == 4'h6 ? {src[0], ef[0], src[7:1]} : {src[7], src[6:0], ef[0]};
    op_valid = 1'b1;
    op_code = code;
    op_addr = addr;
    @(posedge sys_clk);
    #1;
    op_valid = 1'b0;
    n = 0;
    while (op_done !== 1'b1 && n < 20) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (lgl) begin
      ef = {ef[7:4], r[7], r[7:0] == 8'h00, r[7] ^ r[8], r[8]};
      if (code[7:4] == 4'h4) ea = r[7:0];
      else if (code[7:4] == 4'h5) eb = r[7:0];
      else em = r[7:0];
    end
    check(op_done, 1'b1);
    check(illegal_op, !lgl);
    check(acc_a, ea);
    check(acc_b, eb);
    check(flag_register, ef);
    check(i_mem.mem[addr], em);
  endtask
  task automatic t_reset();
    check(acc_a, ACC_RST);
    check(acc_b, ACC_RST);
    check(flag_register, FLAGS_RST);
    check({op_ready, mem_rd, mem_wr, op_done}, 4'h8);
    ea = ACC_RST;
    eb = ACC_RST;
    ef = FLAGS_RST;
  endtask
  task automatic t_acc();
    ld(1, 8'h81);
    ld(2, 8'h40);
    ld(0, 8'hf1);
    exec(OP_LEFT_A, 16'h0000);
    exec(OP_LEFT_B, 16'h0000);
    ld(1, 8'h01);
    exec(OP_RIGHT_A, 16'h0000);
    exec(OP_RIGHT_B, 16'h0000);
  endtask
  task automatic t_mem();
    i_mem.mem[16'h1234] = 8'h80;
    i_mem.mem[16'h00ff] = 8'h01;
    i_mem.mem[16'hab00] = 8'hc3;
    ld(0, 8'h2e);
    exec(OP_LEFT_MEM_EXT, 16'h1234);
    slow = 1'b1;
    exec(OP_RIGHT_MEM_IDX, 16'h00ff);
    exec(OP_LEFT_MEM_IDX, 16'hab00);
    exec(OP_RIGHT_MEM_EXT, 16'h1234);
    slow = 1'b0;
  endtask
  task automatic t_chain();
    i_mem.mem[16'h0010] = 8'hff;
    i_mem.mem[16'h0011] = 8'h00;
    i_mem.mem[16'h0012] = 8'h80;
    ld(0, 8'h00);
    exec(OP_LEFT_MEM_EXT, 16'h0010);
    exec(OP_LEFT_MEM_EXT, 16'h0011);
    exec(OP_LEFT_MEM_EXT, 16'h0012);
  endtask
  task automatic t_btb();
    ld(1, 8'h7f);
    ld(0, 8'h00);
    op_valid = 1'b1;
    op_code = OP_LEFT_A;
    @(posedge sys_clk);
    #1;
    op_code = OP_RIGHT_A;
    check(op_done, 1'b1);
    check({acc_a, flag_register}, 16'hfe0a);
    @(posedge sys_clk);
    #1;
    op_valid = 1'b0;
    check(op_done, 1'b1);
    check({acc_a, flag_register}, 16'h7f00);
    ea = 8'h7f;
    ef = 8'h00;
  endtask
  // A request held while the enable is low must not be taken, and nothing may move.
  task automatic t_freeze();
    ld(1, 8'h55);
    ld(0, 8'h01);
    clk_en = 1'b0;
    op_valid = 1'b1;
    op_code = OP_LEFT_A;
    @(posedge sys_clk);
    #1;
    check({op_done, acc_a}, {1'b0, 8'h55});
    check(flag_register, 8'h01);
    clk_en = 1'b1;
    @(posedge sys_clk);
    #1;
    op_valid = 1'b0;
    check({op_done, acc_a}, {1'b1, 8'hab});
    check(flag_register, 8'h0a);
    ea = 8'hab;
    ef = 8'h0a;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  initial begin
    #200000;
    mismatches++;
    close_out();
  end
  initial begin
    {rst, op_valid, flag_load, acc_a_load, acc_b_load, slow} = 6'h20;
    clk_en = 1'b1;
    {op_code, flag_load_value, acc_load_value, op_addr} = 40'h0;
    i_mem.mem[16'h0000] = 8'h00;
    repeat (2) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    t_reset();
    $display("reset test done");
    t_acc();
    $display("accumulator test done");
    t_mem();
    $display("memory test done");
    t_chain();
    $display("carry chain test done");
    t_btb();
    $display("back to back test done");
    t_freeze();
    $display("clock enable test done");
    exec(8'h47, 16'h0000);
    exec(8'h85, 16'h0000);
    $display("unknown opcode test done");
    close_out();
  end
endmodule
`default_nettype wire
